// ===== rtl/mpc_parity_ctrl.v
/*
 * Memory parity controller: sits between the processor request port
 * and the shared memory port, adds a parity bit per byte on writes,
 * checks it on reads, flags errors and keeps the failing read's high address bits.
 * Assumes processor and memory logic run on the same clock, that the
 * memory answers each read with one mem_rvalid pulse, and that the
 * address select strap comes from a pin outside the clock domain.
 */
`timescale 1ns/1ns
`include "mpc_consts.vh"

// Notes on behaviour
// - Generate parity on writes, check on reads
// - Odd parity, one bit per byte, 18 bits
// - Parity failure raises error software can see
// - Error latches high-order address of failing read
// - Register address selectable 772100 to 772136
// - One controller serves every memory array
module mpc_parity_ctrl (
	clock,
	rst,
	csr_sel_strap,
	proc_req,
	proc_we,
	proc_byte,
	proc_addr,
	proc_wdata,
	mem_rvalid,
	mem_rdata,
	err_clr,
	busy_q,
	mem_req_q,
	mem_we_q,
	mem_be_q,
	mem_addr_q,
	mem_wdata_q,
	proc_rvalid_q,
	proc_rdata_q,
	err_trap_q,
	err_flag_q,
	err_addr_q,
	csr_hit_q
);
	input  wire                     clock;         // 250 MHz clock
	input  wire                     rst;           // Async, active high
	input  wire [`MPC_SEL_W-1:0]    csr_sel_strap; // Address select pins
	input  wire                     proc_req;      // Processor request
	input  wire                     proc_we;       // 1 write, 0 read
	input  wire                     proc_byte;     // Byte access
	input  wire [`MPC_ADDR_W-1:0]   proc_addr;     // Byte address
	input  wire [`MPC_DATA_W-1:0]   proc_wdata;    // Lane-placed data
	input  wire                     mem_rvalid;    // Read data valid
	input  wire [`MPC_STORE_W-1:0]  mem_rdata;     // Data with parity
	input  wire                     err_clr;       // Clear error flag
	output reg                      busy_q;        // Read outstanding
	output reg                      mem_req_q;     // Memory strobe
	output reg                      mem_we_q;      // Memory write
	output reg  [1:0]               mem_be_q;      // Byte enables
	output reg  [`MPC_ADDR_W-1:0]   mem_addr_q;    // Memory address
	output reg  [`MPC_STORE_W-1:0]  mem_wdata_q;   // Data with parity
	output reg                      proc_rvalid_q; // Read answer
	output reg  [`MPC_DATA_W-1:0]   proc_rdata_q;  // Read data
	output reg                      err_trap_q;    // Error pulse
	output reg                      err_flag_q;    // Sticky error
	output reg  [`MPC_EA_W-1:0]     err_addr_q;    // Failing address hi
	output reg                      csr_hit_q;     // Register address hit

	// One-hot controller states
	localparam [1:0] ST_IDLE = 2'b01;
	localparam [1:0] ST_READ = 2'b10;

	reg  [1:0]              state_q;       // Current state
	reg  [1:0]              state_d;       // Next state
	reg  [`MPC_SEL_W-1:0]   sel_meta_q;    // Strap sync, first stage
	reg  [`MPC_SEL_W-1:0]   sel_sync_q;    // Strap sync, second stage
	reg  [`MPC_SEL_W-1:0]   sel_q;         // Strap caught after reset
	reg  [1:0]              sel_age_q;     // Edges since reset release
	reg  [1:0]              rd_be_q;       // Lanes to check on read
	reg  [`MPC_EA_W-1:0]    rd_ahi_q;      // High address of read
	wire [`MPC_DATA_W-1:0]  rd_data;       // Data bits of read word
	wire [1:0]              rd_par;        // Stored parity bits
	wire [1:0]              wr_par;        // Parity for write lanes
	wire [1:0]              rd_bad;        // Per-lane mismatch
	wire [1:0]              chk_unused;    // Read lanes' generated bits
	wire                    take;          // Request accepted
	wire                    is_csr;        // Request hits the register
	wire                    rd_err;        // Checked lane failed
	wire [1:0]              req_be;        // Lanes of this request

	// Lanes touched: both for a word, address bit 0 picks the byte
	function [1:0] lanes;
		input       byte_op;
		input       a0;
		begin
			if (byte_op) begin
				lanes = a0 ? 2'b10 : 2'b01;
			end else begin
				lanes = 2'b11;
			end
		end
	endfunction

	// Register address chosen by select value, word steps from base
	function is_csr_addr;
		input [`MPC_ADDR_W-1:0] a;
		input [`MPC_SEL_W-1:0]  s;
		reg   [`MPC_ADDR_W-1:0] base;
		begin
			base = `MPC_CSR_BASE +
				{{(`MPC_ADDR_W-`MPC_SEL_W-1){1'b0}}, s, 1'b0};
			is_csr_addr = (a[`MPC_ADDR_W-1:1] == base[`MPC_ADDR_W-1:1]);
		end
	endfunction

	assign req_be = lanes(proc_byte, proc_addr[0]);
	assign is_csr = is_csr_addr(proc_addr, sel_q);
	assign take   = proc_req & ~busy_q;

	// Split the stored word into data and parity
	assign rd_data = {mem_rdata[`MPC_HI_DAT_LSB +: `MPC_BYTE_W],
		mem_rdata[`MPC_LO_DAT_LSB +: `MPC_BYTE_W]};
	assign rd_par  = {mem_rdata[`MPC_HI_PAR_BIT],
		mem_rdata[`MPC_LO_PAR_BIT]};

	// Two odd-parity units per byte lane, one for writes and one for reads
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_lane
			// Write side generator
			mpc_byte_parity u_wr (
				.byte_in    (proc_wdata[gi*`MPC_BYTE_W +: `MPC_BYTE_W]),
				.stored_par (1'b0),
				.gen_par    (wr_par[gi]),
				.par_bad    ()
			);
			// Read side checker
			mpc_byte_parity u_rd (
				.byte_in    (rd_data[gi*`MPC_BYTE_W +: `MPC_BYTE_W]),
				.stored_par (rd_par[gi]),
				.gen_par    (chk_unused[gi]),
				.par_bad    (rd_bad[gi])
			);
		end
	endgenerate

	// Only lanes the processor asked for count as failures
	assign rd_err = mem_rvalid & state_q[1] & (|(rd_bad & rd_be_q));

	// Strap synchroniser; second stage is the only reader of the first
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			sel_meta_q <= `MPC_RST_SEL;
			sel_sync_q <= `MPC_RST_SEL;
		end else begin
			sel_meta_q <= csr_sel_strap;
			sel_sync_q <= sel_meta_q;
		end
	end

	// Catch the strap once after reset; a jumper is not live-changed.
	// The catch waits until the second stage holds the pin and not its
	// reset value, which would leave the register at the base address.
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			sel_q     <= `MPC_RST_SEL;
			sel_age_q <= 2'h0;
		end else begin
			// Count up once, then stay put
			if (sel_age_q != `MPC_SEL_DONE) begin
				sel_age_q <= sel_age_q + 2'h1;
			end
			if (sel_age_q == `MPC_SEL_CATCH) begin
				sel_q <= sel_sync_q;
			end
		end
	end

	// Next state
	always @* begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				// Reads to memory wait for the answer
				if (take & ~proc_we & ~is_csr) begin
					state_d = ST_READ;
				end
			end
			ST_READ: begin
				if (mem_rvalid) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// State and busy register
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			state_q <= ST_IDLE;
			busy_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			busy_q  <= state_d[1];
		end
	end

	// Memory port: one strobe per accepted request outside the register address
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			mem_req_q   <= 1'b0;
			mem_we_q    <= 1'b0;
			mem_be_q    <= 2'b00;
			mem_addr_q  <= {`MPC_ADDR_W{1'b0}};
			mem_wdata_q <= {`MPC_STORE_W{1'b0}};
			rd_be_q     <= 2'b00;
			rd_ahi_q    <= `MPC_RST_EA;
		end else begin
			mem_req_q <= take & ~is_csr;
			if (take & ~is_csr) begin
				mem_we_q   <= proc_we;
				mem_addr_q <= proc_addr;
				mem_be_q   <= req_be;
				mem_wdata_q <= {wr_par[1],
					proc_wdata[`MPC_DATA_W-1:`MPC_BYTE_W],
					wr_par[0], proc_wdata[`MPC_BYTE_W-1:0]};
				rd_be_q  <= req_be;
				rd_ahi_q <= proc_addr[`MPC_EA_MSB:`MPC_EA_LSB];
			end
		end
	end

	// Read answer back to the processor, one cycle after data
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			proc_rvalid_q <= 1'b0;
			proc_rdata_q  <= {`MPC_DATA_W{1'b0}};
		end else begin
			proc_rvalid_q <= mem_rvalid & state_q[1];
			if (mem_rvalid & state_q[1]) begin
				proc_rdata_q <= rd_data;
			end
		end
	end

	// Register address decode; no memory cycle is started for it
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			csr_hit_q <= 1'b0;
		end else begin
			csr_hit_q <= take & is_csr;
		end
	end

	// Error reporting: pulse, sticky flag and failing address.
	// A new error in the clearing cycle wins, so none is lost.
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			err_trap_q <= 1'b0;
			err_flag_q <= 1'b0;
			err_addr_q <= `MPC_RST_EA;
		end else begin
			err_trap_q <= rd_err;
			if (rd_err) begin
				err_flag_q <= 1'b1;
				err_addr_q <= rd_ahi_q;
			end else if (err_clr) begin
				err_flag_q <= 1'b0;
			end
		end
	end
endmodule

// ===== rtl/mpc_consts.vh
/*
 * Constants for the memory parity controller: stored word layout,
 * control register address range, error address field and reset values.
 * Assumes an 18-bit bus address and a 16-bit data word of two bytes.
 */
`ifndef MPC_CONSTS_VH
`define MPC_CONSTS_VH

// Word and byte widths
`define MPC_DATA_W      16
`define MPC_BYTE_W      8
`define MPC_STORE_W     18
`define MPC_ADDR_W      18

// Stored word layout: {par_hi, data_hi, par_lo, data_lo}
`define MPC_LO_PAR_BIT  8
`define MPC_HI_PAR_BIT  17
`define MPC_LO_DAT_LSB  0
`define MPC_HI_DAT_LSB  9

// Control register address window, octal, word aligned
`define MPC_CSR_BASE    18'o772100
`define MPC_CSR_LAST    18'o772136
`define MPC_SEL_W       4

// High-order address bits kept on a parity error
`define MPC_EA_MSB      17
`define MPC_EA_LSB      11
`define MPC_EA_W        7

// Reset values
`define MPC_RST_SEL     4'h0
`define MPC_RST_EA      7'h00

// Strap catch timing: edges after reset release
`define MPC_SEL_CATCH   2'h2
`define MPC_SEL_DONE    2'h3

`endif

// ===== rtl/mpc_byte_parity.v
/*
 * One byte lane of odd parity: makes the parity bit for a byte and
 * compares a stored parity bit against the byte it came with.
 * Purely combinational; the caller registers whatever it needs.
 */
`timescale 1ns/1ns
`include "mpc_consts.vh"

module mpc_byte_parity (
	byte_in,
	stored_par,
	gen_par,
	par_bad
);
	input  wire [`MPC_BYTE_W-1:0] byte_in;    // Data byte
	input  wire                   stored_par; // Parity bit read back
	output wire                   gen_par;    // Odd parity for byte_in
	output wire                   par_bad;    // Stored bit disagrees

	// Odd parity: the nine bits together hold an odd count of ones
	assign gen_par = ~(^byte_in);
	// Mismatch means even count over data and stored parity
	assign par_bad = stored_par ^ gen_par;
endmodule

// ===== verification/mpc_parity_ctrl_props.sv
/* Port checker for the parity controller.
   Assumes a steady strap; the lane check takes only requests below the register window. */
`timescale 1ns/1ns
module mpc_parity_ctrl_props (
	input wire		clock,
	input wire		rst,
	input wire [3:0]	csr_sel_strap,
	input wire		proc_req,
	input wire		proc_we,
	input wire		proc_byte,
	input wire [17:0]	proc_addr,
	input wire		mem_rvalid,
	input wire [17:0]	mem_rdata,
	input wire		err_clr,
	input wire		busy_q,
	input wire		mem_req_q,
	input wire		mem_we_q,
	input wire [1:0]	mem_be_q,
	input wire [17:0]	mem_addr_q,
	input wire [17:0]	mem_wdata_q,
	input wire		proc_rvalid_q,
	input wire		err_trap_q,
	input wire		err_flag_q,
	input wire [6:0]	err_addr_q,
	input wire		csr_hit_q
);
	// Enabled lane failing odd parity on returned data
	wire		bad = (mem_be_q[0] & ~^mem_rdata[8:0]) |
		(mem_be_q[1] & ~^mem_rdata[17:9]);
	wire		go = proc_req & ~busy_q;	// Request taken
	wire [17:0]	reg_a = 18'o772100 + {13'h0, csr_sel_strap, 1'b0};
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	a_wr_par_lo: assert property (mem_req_q & mem_we_q & mem_be_q[0]
		|-> ^mem_wdata_q[8:0]) else $error("low lane parity wrong");
	a_wr_par_hi: assert property (mem_req_q & mem_we_q & mem_be_q[1]
		|-> ^mem_wdata_q[17:9]) else $error("high lane parity wrong");
	a_read_busy: assert property (mem_req_q & ~mem_we_q |-> busy_q)
		else $error("read strobe without busy");
	a_read_answer: assert property (busy_q & mem_rvalid
		|=> proc_rvalid_q & ~busy_q) else $error("read not answered");
	a_trap_cause: assert property (busy_q & mem_rvalid
		|=> err_trap_q == $past(bad)) else $error("trap mismatch");
	a_err_addr: assert property (err_trap_q |-> err_flag_q &&
		err_addr_q == mem_addr_q[17:11]) else $error("error address bad");
	a_flag_clear: assert property (err_clr |=> err_flag_q == err_trap_q)
		else $error("flag not cleared");
	a_byte_lane: assert property (go & proc_we & proc_byte &
		proc_addr < 18'o772100 |=> mem_req_q && mem_be_q ==
		($past(proc_addr[0]) ? 2'b10 : 2'b01)) else $error("lane enable bad");
	a_reg_hit: assert property (go & proc_addr == reg_a
		|=> csr_hit_q & ~mem_req_q) else $error("register hit bad");
	c_trap: cover property (err_trap_q);
	c_hit: cover property (csr_hit_q);
	c_byte: cover property (mem_req_q & mem_we_q & mem_be_q != 2'b11);
endmodule
bind mpc_parity_ctrl mpc_parity_ctrl_props chk (.*);

// ===== verification/mpc_mem_model.sv
/* Memory array on the far side of the controller.
   Assumes one strobe per access; flip corrupts returned parity. */
`timescale 1ns/1ns
module mpc_mem_model (
	input wire		clock,
	input wire		req,
	input wire		we,
	input wire [1:0]	be,
	input wire [17:0]	addr,
	input wire [17:0]	wdata,
	input wire [1:0]	flip,
	input wire [2:0]	lat,
	output logic		rvalid = 0,
	output logic [17:0]	rdata = '1
);
	logic [17:0]	mem [0:63];	// Words with parity bits
	// Only enabled lanes stored; other lane keeps its parity
	always @(posedge clock) begin
		if (req & we & be[0]) mem[addr[6:1]][8:0] <= wdata[8:0];
		if (req & we & be[1]) mem[addr[6:1]][17:9] <= wdata[17:9];
	end
	// Slow or prompt answer; data inverted once released
	always @(posedge clock) begin
		if (req & ~we) begin
			repeat (lat) @(posedge clock);
			#1 rvalid = 1;
			rdata = mem[addr[6:1]] ^ {flip[1], 8'h0, flip[0], 8'h0};
			@(posedge clock);
			#1 rvalid = 0;
			rdata = ~rdata;
		end
	end
endmodule

// ===== verification/tb.sv
/* Self-checking bench for the parity controller and memory model.
   Assumes the address strap is tied to its top setting. */
`timescale 1ns/1ns
`define CHK(n, e, s) begin check_count++; if ((e) !== (s)) begin \
	mismatches++; $display("mismatch %s exp %h got %h", n, e, s); end end
module tb;
	logic		clock = 0, rst = 1, proc_req = 0, proc_we = 0;
	logic		proc_byte = 0, err_clr = 0, mem_rvalid;
	logic [3:0]	csr_sel_strap = 4'hf;
	logic [17:0]	proc_addr = 0, mem_rdata, mem_addr_q, mem_wdata_q;
	logic [15:0]	proc_wdata = 0, proc_rdata_q, exp_mem [64];
	logic [1:0]	mem_be_q, flip = 0;
	logic [2:0]	lat = 1;
	logic [6:0]	err_addr_q;
	logic		busy_q, mem_req_q, mem_we_q, proc_rvalid_q;
	logic		err_trap_q, err_flag_q, csr_hit_q;
	int		mismatches = 0, check_count = 0;
	int		traps = 0;
	bit [31:0]	seed = 32'hd99fa9bf, r;
	always #2 clock = ~clock;
	mpc_parity_ctrl DUT (.*);
	mpc_mem_model mem (.clock, .req(mem_req_q), .we(mem_we_q),
		.be(mem_be_q), .addr(mem_addr_q), .wdata(mem_wdata_q), .flip,
		.lat, .rvalid(mem_rvalid), .rdata(mem_rdata));
	function automatic bit [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic bit [17:0] adr(int i);
		return {1'b0, 6'(i * 5), 4'h0, 6'(i), 1'b0};
	endfunction
	task automatic tick(int n = 1);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// One request; a read waits for its answer under a bound
	task automatic access(bit we, bit bt, bit [17:0] a, bit [15:0] d);
		proc_req = 1;
		proc_we = we;
		proc_byte = bt;
		proc_addr = a;
		proc_wdata = d;
		tick();
		proc_req = 0;
		for (int i = 0; i < 20 && !we && proc_rvalid_q !== 1; i++) tick();
		if (!we && proc_rvalid_q !== 1) begin
			mismatches++;
			summarize();
		end
	endtask
	initial begin
		tick(3);
		rst = 0;
		tick(4);
		// Back-to-back word writes of random data
		for (int i = 0; i < 16; i++) begin
			exp_mem[i] = rnd();
			access(1, 0, adr(i), exp_mem[i]);
			`CHK("be", 2'b11, mem_be_q)
		end
		// Byte writes touch one lane only
		for (int i = 0; i < 8; i++) begin
			r = rnd();
			access(1, 1, adr(i) | r[0], {2{r[15:8]}});
			if (r[0]) exp_mem[i][15:8] = r[15:8];
			else exp_mem[i][7:0] = r[15:8];
			`CHK("lane", r[0] ? 2'b10 : 2'b01, mem_be_q)
		end
		$display("writes done");
		// Reads, last three with corrupted parity, the last in both lanes
		for (int i = 0; i < 16; i++) begin
			flip = i > 12 ? 2'(i - 12) : 2'b00;
			lat = 3'(rnd() % 4 + 1);
			access(0, 0, adr(i), 0);
			`CHK("data", exp_mem[i], proc_rdata_q)
			`CHK("trap", flip != 0, err_trap_q)
			if (flip != 0) `CHK("ea", 7'(6'(i * 5)), err_addr_q)
			if (err_trap_q === 1'b1) traps++;
		end
		`CHK("traps", 3, traps)
		// Byte reads check only their own lane
		for (int i = 0; i < 2; i++) begin
			flip = i ? 2'b01 : 2'b10;
			access(0, 1, adr(i) | 18'(i), 0);
			`CHK("bytetrap", 1'b0, err_trap_q)
			`CHK("byte", exp_mem[i][i*8 +: 8], proc_rdata_q[i*8 +: 8])
		end
		flip = 0;
		$display("reads done");
		err_clr = 1;
		tick();
		err_clr = 0;
		`CHK("flag", 1'b0, err_flag_q)
		access(1, 0, 18'o772136, 0);
		`CHK("hit", 2'b10, {csr_hit_q, mem_req_q})
		$display("register done");
		summarize();
	end
endmodule
